/* File: design/rcr_defs.svh */
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// =====================================================================
// register offsets
`define RCR_OFS_COMMAND   8'h00
`define RCR_OFS_STATUS    8'h04
`define RCR_OFS_CONFIG    8'h08

// =====================================================================
// field positions
`define RCR_KEY_VALUE     8'hA5
`define RCR_KEY_HI        31
`define RCR_KEY_LO        24
`define RCR_CMD_CPU_BIT   0
`define RCR_CMD_PERI_BIT  2
`define RCR_CMD_PIN_BIT   3
`define RCR_ST_FALL_BIT   0
`define RCR_ST_CAUSE_HI   10
`define RCR_ST_CAUSE_LO   8
`define RCR_ST_LEVEL_BIT  16
`define RCR_ST_BUSY_BIT   17
`define RCR_CFG_EN_BIT    0
`define RCR_CFG_IRQ_BIT   4
`define RCR_CFG_LEN_HI    11
`define RCR_CFG_LEN_LO    8

// =====================================================================
// reset values and timing
`define RCR_CFG_RESET     32'h0000_0001
`define RCR_SW_RESET_SLOW 3
`define RCR_SYNC_STAGES   2

`endif

/* File: design/rcr_pkg.sv */
package rcr_pkg;
   typedef enum logic [2:0] {
      RCR_CAUSE_GENERAL  = 3'h0,
      RCR_CAUSE_BACKUP   = 3'h1,
      RCR_CAUSE_WATCHDOG = 3'h2,
      RCR_CAUSE_SOFTWARE = 3'h3,
      RCR_CAUSE_PIN      = 3'h4
   } rcr_cause_t;

   typedef enum logic [1:0] {
      RCR_IDLE  = 2'b00,
      RCR_HOLD  = 2'b01,
      RCR_PULSE = 2'b11
   } rcr_state_t;
endpackage

/* File: design/rcr_sync.sv */
module rcr_sync (
   input  wire logic CLOCK_IN,
   input  wire logic RST_IN,
   input  wire logic D_IN,
   output logic      Q_OUT
);
   logic meta_q;

   // reset high: pin idles high
   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         meta_q <= 1'b1;
         Q_OUT  <= 1'b1;
      end else begin
         meta_q <= D_IN;
         Q_OUT  <= meta_q;
      end
   end
endmodule

/* File: design/rcr_top.sv */
// Chosen here: register access over APB.
`include "rcr_defs.svh"
// Function
// RQ1 - command write needs key 0xA5
// RQ2 - command bit 0 resets processor
// RQ3 - command bit 2 resets peripherals
// RQ4 - command bit 3 drives pin low
// RQ5 - pin falling edge sets status flag
// RQ6 - interrupt when flag, enable, pin-reset off
// RQ7 - status read clears fall flag
// RQ8 - status 10:8 hold last reset cause
// RQ9 - status read keeps cause field
// RQ10 - status bit 16 shows pin level
// RQ11 - status bit 17 busy during software reset
// RQ12 - software waits for busy before commanding
// RQ13 - config write blocked by write protect
// RQ14 - config bit 0 enables pin reset
// RQ15 - pin pulse lasts 2^(len+1) slow cycles
// RQ16 - config write needs key, key reads zero
// RQ17 - software reset lasts three slow cycles
// RQ18 - command ignored while busy
// RQ19 - cause updated at processor reset release
// RQ20 - cause software only with processor bit
// RQ21 - reserved bits read zero
module rcr_top (
   input  wire logic                 CLOCK_IN,
   input  wire logic                 RST_IN,
   input  wire logic                 PSEL_IN,
   input  wire logic                 PENABLE_IN,
   input  wire logic                 PWRITE_IN,
   input  wire logic [7:0]           PADDR_IN,
   input  wire logic [31:0]          PWDATA_IN,
   input  wire logic                 SLOW_CLOCK_IN,
   input  wire logic                 PIN_IN,
   input  wire logic                 WRITE_PROTECT_ON_IN,
   input  wire rcr_pkg::rcr_cause_t  EXT_CAUSE_IN,
   input  wire logic                 EXT_CAUSE_VALID_IN,
   output logic [31:0]               PRDATA_OUT,
   output logic                      PREADY_OUT,
   output logic                      PSLVERR_OUT,
   output logic                      PIN_OUT,
   output logic                      PIN_OE_OUT,
   output logic                      CPU_RESET_OUT,
   output logic                      PERIPH_RESET_OUT,
   output logic                      IRQ_OUT
);
   import rcr_pkg::*;

   // =====================================================================
   // input synchronisers
   logic       pin_s;
   logic       slow_s;
   logic       pin_d_q;
   logic       slow_d_q;
   logic       slow_tick;
   logic       pin_fall;

   rcr_sync u_pin_sync (
      .CLOCK_IN (CLOCK_IN),
      .RST_IN   (RST_IN),
      .D_IN     (PIN_IN),
      .Q_OUT    (pin_s)
   );

   rcr_sync u_slow_sync (
      .CLOCK_IN (CLOCK_IN),
      .RST_IN   (RST_IN),
      .D_IN     (SLOW_CLOCK_IN),
      .Q_OUT    (slow_s)
   );

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         pin_d_q  <= 1'b1;
         // matches the synchroniser's reset level, so no false tick after reset
         slow_d_q <= 1'b1;
      end else begin
         pin_d_q  <= pin_s;
         slow_d_q <= slow_s;
      end
   end

   assign slow_tick = slow_s & ~slow_d_q;
   assign pin_fall  = pin_d_q & ~pin_s;

   // =====================================================================
   // apb decode
   logic       acc;
   logic       wr;
   logic       rd;
   logic       key_ok;
   logic       mapped;
   logic       cmd_go;
   logic       cfg_wr;
   logic       st_rd;
   logic       busy_q;

   assign acc    = PSEL_IN & PENABLE_IN;
   assign wr     = acc & PWRITE_IN;
   assign rd     = acc & ~PWRITE_IN;
   assign key_ok = PWDATA_IN[`RCR_KEY_HI:`RCR_KEY_LO] == `RCR_KEY_VALUE;
   assign mapped = PADDR_IN == `RCR_OFS_COMMAND || PADDR_IN == `RCR_OFS_STATUS
                   || PADDR_IN == `RCR_OFS_CONFIG;
   assign st_rd  = rd & (PADDR_IN == `RCR_OFS_STATUS);
   // RQ1 RQ18
   assign cmd_go = wr & (PADDR_IN == `RCR_OFS_COMMAND) & key_ok & ~busy_q
                   & (PWDATA_IN[`RCR_CMD_CPU_BIT] | PWDATA_IN[`RCR_CMD_PERI_BIT]
                      | PWDATA_IN[`RCR_CMD_PIN_BIT]);
   // RQ13 RQ16
   assign cfg_wr = wr & (PADDR_IN == `RCR_OFS_CONFIG) & key_ok & ~WRITE_PROTECT_ON_IN;

   // =====================================================================
   // configuration
   logic       pin_en_q;
   logic       irq_en_q;
   logic [3:0] len_exp_q;

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         pin_en_q  <= 1'(`RCR_CFG_RESET >> `RCR_CFG_EN_BIT);
         irq_en_q  <= 1'b0;
         len_exp_q <= 4'h0;
      end else if (cfg_wr) begin
         pin_en_q  <= PWDATA_IN[`RCR_CFG_EN_BIT]; // RQ14
         irq_en_q  <= PWDATA_IN[`RCR_CFG_IRQ_BIT];
         len_exp_q <= PWDATA_IN[`RCR_CFG_LEN_HI:`RCR_CFG_LEN_LO];
      end
   end

   // =====================================================================
   // software reset sequencer
   rcr_state_t st_q;
   logic       cpu_cmd_q;
   logic       peri_cmd_q;
   logic [1:0] sw_cnt_q;

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         busy_q     <= 1'b0;
         cpu_cmd_q  <= 1'b0;
         peri_cmd_q <= 1'b0;
         sw_cnt_q   <= 2'h0;
      end else if (cmd_go) begin
         busy_q     <= 1'b1; // RQ11
         cpu_cmd_q  <= PWDATA_IN[`RCR_CMD_CPU_BIT]; // RQ2
         peri_cmd_q <= PWDATA_IN[`RCR_CMD_PERI_BIT]; // RQ3
         sw_cnt_q   <= 2'h0;
      end else if (busy_q && slow_tick) begin
         // RQ17
         if (sw_cnt_q == 2'(`RCR_SW_RESET_SLOW - 1)) begin
            busy_q     <= 1'b0; // RQ11
            cpu_cmd_q  <= 1'b0;
            peri_cmd_q <= 1'b0;
         end else begin
            sw_cnt_q <= sw_cnt_q + 2'h1;
         end
      end
   end

   // =====================================================================
   // external pin pulse
   logic [16:0] pulse_cnt_q;
   logic [16:0] pulse_len;

   assign pulse_len = 17'(2) << len_exp_q; // RQ15

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         st_q        <= RCR_IDLE;
         pulse_cnt_q <= 17'h0;
      end else begin
         case (st_q)
            RCR_IDLE: begin
               if (cmd_go && PWDATA_IN[`RCR_CMD_PIN_BIT]) begin
                  st_q        <= RCR_HOLD; // RQ4
                  pulse_cnt_q <= 17'h0;
               end
            end
            RCR_HOLD: begin
               if (slow_tick) begin
                  st_q <= RCR_PULSE;
               end
            end
            RCR_PULSE: begin
               if (slow_tick) begin
                  if (pulse_cnt_q == pulse_len - 17'h1) begin
                     st_q <= RCR_IDLE;
                  end else begin
                     pulse_cnt_q <= pulse_cnt_q + 17'h1;
                  end
               end
            end
            default: st_q <= RCR_IDLE;
         endcase
      end
   end

   // open-drain: drive low only
   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         PIN_OUT    <= 1'b0;
         PIN_OE_OUT <= 1'b0;
      end else begin
         PIN_OUT    <= 1'b0;
         PIN_OE_OUT <= (st_q != RCR_IDLE) | (cmd_go & PWDATA_IN[`RCR_CMD_PIN_BIT]); // RQ4
      end
   end

   // =====================================================================
   // reset outputs, user reset via pin
   logic       user_rst;
   logic       user_rst_q;
   logic       sw_end;
   logic [2:0] own_hist_q;

   assign sw_end = busy_q & slow_tick & (sw_cnt_q == 2'(`RCR_SW_RESET_SLOW - 1));

   // pin stays low for the sync delay after our own pulse; that tail must not
   // look like a button press
   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         own_hist_q <= 3'h0;
      end else begin
         own_hist_q <= {own_hist_q[1:0], PIN_OE_OUT};
      end
   end

   // own pulse and software reset do not count as user reset
   assign user_rst = pin_en_q & ~pin_s & (st_q == RCR_IDLE) & ~busy_q
                     & ~PIN_OE_OUT & ~(|own_hist_q); // RQ14

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         user_rst_q       <= 1'b0;
         CPU_RESET_OUT    <= 1'b0;
         PERIPH_RESET_OUT <= 1'b0;
      end else begin
         user_rst_q       <= user_rst;
         CPU_RESET_OUT    <= user_rst | (cmd_go & PWDATA_IN[`RCR_CMD_CPU_BIT])
                             | (cpu_cmd_q & busy_q & ~sw_end);
         PERIPH_RESET_OUT <= user_rst | (cmd_go & PWDATA_IN[`RCR_CMD_PERI_BIT])
                             | (peri_cmd_q & busy_q & ~sw_end);
      end
   end

   // =====================================================================
   // reset cause, loaded on EXT_CAUSE_VALID_IN or on processor reset release
   rcr_cause_t cause_q;

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cause_q <= RCR_CAUSE_GENERAL;
      end else if (EXT_CAUSE_VALID_IN) begin
         cause_q <= EXT_CAUSE_IN;
      end else if (sw_end && cpu_cmd_q) begin
         cause_q <= RCR_CAUSE_SOFTWARE; // RQ19 RQ20
      end else if (user_rst_q && !user_rst) begin
         cause_q <= RCR_CAUSE_PIN; // RQ19
      end
   end

   // =====================================================================
   // falling edge flag and interrupt
   logic fall_q;

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         fall_q <= 1'b0;
      end else if (pin_fall) begin
         fall_q <= 1'b1; // RQ5 (set beats read clear)
      end else if (st_rd) begin
         fall_q <= 1'b0; // RQ7
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= (fall_q | pin_fall) & ~(st_rd & ~pin_fall) & irq_en_q & ~pin_en_q; // RQ6
      end
   end

   // =====================================================================
   // read data
   logic [31:0] rdata;

   always_comb begin
      rdata = 32'h0; // RQ21
      case (PADDR_IN)
         `RCR_OFS_STATUS: begin
            rdata[`RCR_ST_FALL_BIT]                  = fall_q;
            rdata[`RCR_ST_CAUSE_HI:`RCR_ST_CAUSE_LO] = cause_q; // RQ8 RQ9
            rdata[`RCR_ST_LEVEL_BIT]                 = pin_s; // RQ10
            rdata[`RCR_ST_BUSY_BIT]                  = busy_q;
         end
         `RCR_OFS_CONFIG: begin
            rdata[`RCR_CFG_EN_BIT]                 = pin_en_q;
            rdata[`RCR_CFG_IRQ_BIT]                = irq_en_q;
            rdata[`RCR_CFG_LEN_HI:`RCR_CFG_LEN_LO] = len_exp_q; // RQ16 key reads 0
         end
         default: rdata = 32'h0;
      endcase
   end

   // single-cycle apb; no wait state, outputs registered from the setup phase
   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         PRDATA_OUT  <= 32'h0;
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
      end else begin
         PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
         PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & ~mapped;
         PRDATA_OUT  <= (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) ? rdata : 32'h0;
      end
   end

   // =====================================================================
   // checks
   property p_key;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         wr && PADDR_IN == `RCR_OFS_COMMAND && !key_ok |=> !$rose(busy_q);
   endproperty
   a_key: assert property (p_key) else $error("bad key started reset"); // RQ1

   property p_cpu;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         cmd_go && PWDATA_IN[0] |=> CPU_RESET_OUT;
   endproperty
   a_cpu: assert property (p_cpu) else $error("cpu reset missing"); // RQ2

   property p_pin;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         cmd_go && PWDATA_IN[3] |=> PIN_OE_OUT && !PIN_OUT;
   endproperty
   a_pin: assert property (p_pin) else $error("pin not driven"); // RQ4

   property p_fall;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         pin_fall |=> fall_q;
   endproperty
   a_fall: assert property (p_fall) else $error("fall flag not set"); // RQ5

   property p_clr;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         st_rd && !pin_fall |=> !fall_q;
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared"); // RQ7

   property p_cause;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         st_rd && !EXT_CAUSE_VALID_IN && !sw_end && !(user_rst_q && !user_rst)
         |=> $stable(cause_q);
   endproperty
   a_cause: assert property (p_cause) else $error("cause changed on read"); // RQ9

   property p_busy;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         busy_q && wr && PADDR_IN == `RCR_OFS_COMMAND && !sw_end
         |=> busy_q && $stable(cpu_cmd_q) && $stable(peri_cmd_q);
   endproperty
   a_busy: assert property (p_busy) else $error("command taken while busy"); // RQ18

   property p_prot;
      @(posedge CLOCK_IN) disable iff (RST_IN)
         WRITE_PROTECT_ON_IN |=> $stable(len_exp_q) && $stable(pin_en_q);
   endproperty
   a_prot: assert property (p_prot) else $error("protected config written"); // RQ13
endmodule

/* File: tb/rcr_pin_model.sv */
// =====================================================
// board side of the reset pin: pull-up, push button, slow clock
module rcr_pin_model #(
   parameter int SLOW_HALF_NS = 100
) (
   input  wire logic pin_oe_in,
   input  wire logic pin_drv_in,
   input  wire logic press_in,
   output logic      pin_level_out,
   output logic      slow_clock_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // open-drain line: released means the pull-up wins
   assign pin_level_out = ((pin_oe_in && !pin_drv_in) || press_in) ? 1'b0 : 1'b1;

   // slow oscillator runs free, unrelated to the master clock
   initial slow_clock_out = 1'b0;
   always #(SLOW_HALF_NS) slow_clock_out = ~slow_clock_out;
endmodule

/* File: tb/reset_controller_regs_tb_top.sv */
module reset_controller_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rcr_pkg::*;

   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             psel = 1'b0;
   logic             pen = 1'b0;
   logic             pwr = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0;
   logic             wp = 1'b0;
   logic             cv = 1'b0;
   logic             press = 1'b0;
   rcr_cause_t       cause_in = RCR_CAUSE_GENERAL;
   logic [31:0]      prdata;
   logic             pready, pslverr, pin_drv, pin_oe, cpu_rst, per_rst, irq;
   logic             slow, pin_lvl;
   logic [33:0]      exp_q[$];
   int               miscompares = 0;
   int               compares = 0;
   int               oe_slow = 0;

   always #10 clk = ~clk;

   rcr_top u_dut (.CLOCK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .SLOW_CLOCK_IN(slow),
      .PIN_IN(pin_lvl), .WRITE_PROTECT_ON_IN(wp), .EXT_CAUSE_IN(cause_in),
      .EXT_CAUSE_VALID_IN(cv), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .PIN_OUT(pin_drv), .PIN_OE_OUT(pin_oe),
      .CPU_RESET_OUT(cpu_rst), .PERIPH_RESET_OUT(per_rst), .IRQ_OUT(irq));

   rcr_pin_model u_pin (.pin_oe_in(pin_oe), .pin_drv_in(pin_drv), .press_in(press),
      .pin_level_out(pin_lvl), .slow_clock_out(slow));

   always @(posedge slow) if (pin_oe === 1'b1) oe_slow++;

   // =====================================================
   // checking and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish;
      if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic logic [31:0] st(input logic b, input logic [2:0] c, input logic f);
      return {14'h0, b, 1'b1, 5'h0, c, 7'h0, f};
   endfunction

   // =====================================================
   // bus master: result is noted before the request goes out
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
      int n;
      exp_q.push_back({~wr, err, e});
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         tally_and_finish();
      end
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      logic [33:0] e;
      if (pready === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]});
         if (e[33]) check(prdata, e[31:0]);
      end
   end

   // reset outputs may outlive busy, so wait on them with a bound
   task automatic wait_idle;
      int n;
      n = 0;
      while ({cpu_rst, per_rst, pin_oe} !== 3'b000 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) begin
         miscompares++;
         tally_and_finish();
      end
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end

   // =====================================================
   // scenarios
   initial begin
      logic [31:0] r;
      logic [3:0]  cmds [4];
      logic [2:0]  cz;
      cmds = '{4'h1, 4'h4, 4'h8, 4'hD};
      cz = 3'h0;
      void'($urandom(32'h5BD37F82));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      xfer(1'b0, 8'h08, 32'h0, 32'h0000_0001, 1'b0);
      xfer(1'b0, 8'h04, 32'h0, st(1'b0, 3'h0, 1'b0), 1'b0);
      xfer(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
      xfer(1'b1, 8'h0C, 32'h0, 32'h0, 1'b1);
      xfer(1'b1, 8'h04, 32'hFFFF_FFFF, 32'h0, 1'b0);
      r = $urandom();
      xfer(1'b1, 8'h08, {8'h5A, r[23:0]}, 32'h0, 1'b0);
      wp <= 1'b1;
      xfer(1'b1, 8'h08, {8'hA5, r[23:0]}, 32'h0, 1'b0);
      wp <= 1'b0;
      xfer(1'b0, 8'h08, 32'h0, 32'h0000_0001, 1'b0);
      xfer(1'b1, 8'h08, {8'hA5, r[23:0]}, 32'h0, 1'b0);
      xfer(1'b0, 8'h08, 32'h0, {20'h0, r[11:8], 3'h0, r[4], 3'h0, r[0]}, 1'b0);
      xfer(1'b1, 8'h08, 32'hA500_0100, 32'h0, 1'b0);
      xfer(1'b1, 8'h00, 32'h5A00_000D, 32'h0, 1'b0);
      check({29'h0, cpu_rst, per_rst, pin_oe}, 32'h0);
      foreach (cmds[i]) begin
         oe_slow = 0;
         xfer(1'b1, 8'h00, {8'hA5, 20'h0, cmds[i]}, 32'h0, 1'b0);
         check({pin_drv, cpu_rst, per_rst, pin_oe},
               {1'b0, cmds[i][0], cmds[i][2], cmds[i][3]});
         // a second command inside busy must not land
         xfer(1'b1, 8'h00, 32'hA500_000F, 32'h0, 1'b0);
         if (!cmds[i][3]) xfer(1'b0, 8'h04, 32'h0, st(1'b1, cz, 1'b0), 1'b0);
         wait_idle();
         repeat (40) @(posedge clk);
         if (cmds[i][3]) check({31'h0, oe_slow >= 4 && oe_slow <= 6}, 32'h1);
         if (cmds[i][0]) cz = RCR_CAUSE_SOFTWARE;
         xfer(1'b0, 8'h04, 32'h0, st(1'b0, cz, cmds[i][3]), 1'b0);
         xfer(1'b0, 8'h04, 32'h0, st(1'b0, cz, 1'b0), 1'b0);
      end
      xfer(1'b1, 8'h08, 32'hA500_0010, 32'h0, 1'b0);
      press <= 1'b1;
      repeat (20) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      check({31'h0, cpu_rst}, 32'h0);
      press <= 1'b0;
      repeat (20) @(posedge clk);
      xfer(1'b0, 8'h04, 32'h0, st(1'b0, cz, 1'b1), 1'b0);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      xfer(1'b1, 8'h08, 32'hA500_0011, 32'h0, 1'b0);
      press <= 1'b1;
      repeat (20) @(posedge clk);
      check({30'h0, cpu_rst, irq}, 32'h2);
      press <= 1'b0;
      wait_idle();
      repeat (40) @(posedge clk);
      xfer(1'b0, 8'h04, 32'h0, st(1'b0, 3'h4, 1'b1), 1'b0);
      cause_in <= RCR_CAUSE_WATCHDOG;
      cv <= 1'b1;
      @(posedge clk);
      cv <= 1'b0;
      repeat (2) @(posedge clk);
      xfer(1'b0, 8'h04, 32'h0, st(1'b0, 3'h2, 1'b0), 1'b0);
      tally_and_finish();
   end
endmodule
